/* hdl/sdc_device.sv */
`timescale 1ns/10ps
module sdc_device
    import sdc_pkg::*;
#(
    parameter bit AUTOMOTIVE = 1'b0
) (
    input wire logic clk, // device clock
    input wire logic rst, // async reset
    input wire sdc_cmd_bus_t cmd_in, // strobes, address, masks
    input wire logic [DATA_BITS-1:0] dq_in, // write data
    output logic [DATA_BITS-1:0] dq_out, // read data
    output logic [DATA_BITS-1:0] dq_oe, // per-line drive enable
    output logic [ROW_BITS-1:0] refresh_row, // internal refresh row
    output logic self_refresh, // in self refresh
    output logic [NUM_BANKS-1:0] bank_open, // banks with open row
    output logic [11:0] config_word // last config load op-code
);
    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    sdc_cmd_t cmd;
    logic sel;
    logic [1:0] bank;
    logic is_act;
    logic is_rd;
    logic is_wr;
    logic is_term;
    logic is_pre;
    logic is_ref;
    logic is_cfg;
    logic ap;

    // strobes valid at rising edge, decoded only when selected
    assign cmd = sdc_cmd_t'({cmd_in.ras_n, cmd_in.cas_n, cmd_in.we_n});
    assign sel = !cmd_in.cs_n && !self_refresh;
    assign bank = {cmd_in.bank_select_hi, cmd_in.bank_select_lo};
    assign is_act = sel && cmd == SDC_CMD_ACTIVE;
    assign is_rd = sel && cmd == SDC_CMD_READ;
    assign is_wr = sel && cmd == SDC_CMD_WRITE;
    assign is_term = sel && cmd == SDC_CMD_TERMINATE;
    assign is_pre = sel && cmd == SDC_CMD_PRECHARGE;
    assign is_ref = sel && cmd == SDC_CMD_REFRESH;
    assign is_cfg = sel && cmd == SDC_CMD_CONFIG_LOAD;
    assign ap = cmd_in.addr[AP_LINE];

    // ------------------------------------------------------------
    // bank state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SDC_BANK_IDLE = 2'b00,
        SDC_BANK_OPEN = 2'b01,
        SDC_BANK_PRECHARGING = 2'b10
    } sdc_bank_t;

    sdc_bank_t bank_q [NUM_BANKS];
    logic [ROW_BITS-1:0] row_q [NUM_BANKS];
    logic [3:0] bank_wait_q [NUM_BANKS];
    logic burst_on_q;
    logic burst_wr_q;
    logic burst_ap_q;
    logic [1:0] burst_bank_q;
    logic [2:0] burst_cnt_q;
    logic [COL_BITS-1:0] col_q;
    logic burst_end;

    assign burst_end = burst_on_q && burst_cnt_q == BL_LAST;

    // per bank open, close and precharge wait
    genvar g;
    generate
        for (g = 0; g < NUM_BANKS; g++) begin : g_bank
            logic close_now;
            assign close_now = (is_pre && (ap || bank == 2'(g)))
                || (burst_end && burst_ap_q
                    && burst_bank_q == 2'(g));
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    bank_q[g] <= SDC_BANK_IDLE;
                    row_q[g] <= '0;
                    bank_wait_q[g] <= '0;
                end else if (close_now
                        && bank_q[g] == SDC_BANK_OPEN) begin
                    bank_q[g] <= SDC_BANK_PRECHARGING;
                    bank_wait_q[g] <= PRE_CK;
                end else if (is_act && bank == 2'(g)
                        && bank_q[g] == SDC_BANK_IDLE) begin
                    bank_q[g] <= SDC_BANK_OPEN;
                    row_q[g] <= cmd_in.addr[ROW_BITS-1:0];
                end else if (bank_q[g] == SDC_BANK_PRECHARGING) begin
                    if (bank_wait_q[g] <= 4'h1) begin
                        bank_q[g] <= SDC_BANK_IDLE;
                    end
                    bank_wait_q[g] <= bank_wait_q[g] - 4'h1;
                end
            end
            assign bank_open[g] = bank_q[g] == SDC_BANK_OPEN;
        end
    endgenerate

    // ------------------------------------------------------------
    // burst engine
    // ------------------------------------------------------------
    logic start_rd;
    logic start_wr;
    logic bank_ok;

    assign bank_ok = bank_q[bank] == SDC_BANK_OPEN;
    assign start_rd = is_rd && bank_ok;
    assign start_wr = is_wr && bank_ok;

    // new column command restarts; terminate ends latest burst
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            burst_on_q <= 1'b0;
            burst_wr_q <= 1'b0;
            burst_ap_q <= 1'b0;
            burst_bank_q <= '0;
            burst_cnt_q <= '0;
            col_q <= '0;
        end else if (start_rd || start_wr) begin
            burst_on_q <= 1'b1;
            burst_wr_q <= start_wr;
            burst_ap_q <= ap;
            burst_bank_q <= bank;
            burst_cnt_q <= 3'h1;
            col_q <= cmd_in.addr[COL_BITS-1:0] + 9'h1;
        end else if (is_term || burst_end) begin
            burst_on_q <= 1'b0;
            burst_cnt_q <= '0;
        end else if (burst_on_q) begin
            burst_cnt_q <= burst_cnt_q + 3'h1;
            col_q <= col_q + 9'h1;
        end
    end

    // ------------------------------------------------------------
    // write path through fifo into the array
    // ------------------------------------------------------------
    sdc_word_t wr_word;
    sdc_word_t fifo_word;
    logic wr_beat;
    logic fifo_in_ready;
    logic fifo_valid;
    logic [MEM_ABITS-1:0] mem_addr;
    logic [MEM_ABITS-1:0] wr_addr_q;
    logic [MEM_ABITS-1:0] beat_addr;
    logic rd_beat;

    // column addressing folded onto the modelled array
    assign beat_addr = (start_rd || start_wr)
        ? MEM_ABITS'({bank, cmd_in.addr[5:0]})
        : MEM_ABITS'({burst_bank_q, col_q[5:0]});
    // the edge that ends a burst still carries its last beat;
    // only a terminate or a new column command drops the beat
    assign wr_beat = start_wr
        || (burst_on_q && burst_wr_q && !is_term
            && !start_rd);
    assign rd_beat = start_rd
        || (burst_on_q && !burst_wr_q && !is_term
            && !start_wr);
    assign wr_word.mask = cmd_in.mask;
    assign wr_word.data = dq_in;

    // one fifo entry per beat, address captured alongside
    sdc_fifo #(
        .WIDTH($bits(sdc_word_t) + MEM_ABITS),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(wr_beat),
        .in_ready(fifo_in_ready),
        .in_data({beat_addr, wr_word}),
        .out_valid(fifo_valid),
        .out_ready(!rd_beat),
        .out_data({wr_addr_q, fifo_word})
    );

    // reads take the array port; writes drain when free
    assign mem_addr = rd_beat ? beat_addr : wr_addr_q;

    sdc_mem u_mem (
        .clk(clk),
        .wr_en(fifo_valid && !rd_beat),
        .wr_mask(fifo_word.mask),
        .addr(mem_addr),
        .wr_data(fifo_word.data),
        .rd_data(dq_out)
    );

    // ------------------------------------------------------------
    // read output enable, mask delayed two clocks
    // ------------------------------------------------------------
    logic [MASK_BITS-1:0] mask_d1_q;
    logic rd_d1_q;

    // mask sampled now governs the data two edges later
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mask_d1_q <= '1;
            rd_d1_q <= 1'b0;
            dq_oe <= '0;
        end else begin
            mask_d1_q <= cmd_in.mask;
            rd_d1_q <= rd_beat;
            for (int i = 0; i < DATA_BITS; i++) begin
                dq_oe[i] <= rd_d1_q && !mask_d1_q[i/8];
            end
        end
    end

    // ------------------------------------------------------------
    // refresh, config load and self refresh
    // ------------------------------------------------------------
    logic [3:0] busy_q;
    logic all_idle;

    assign all_idle = bank_open == '0 && !burst_on_q;

    // internal row counter shared by both refresh modes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            refresh_row <= '0;
            busy_q <= '0;
            config_word <= '0;
            self_refresh <= 1'b0;
        end else begin
            if (busy_q != 4'h0) begin
                busy_q <= busy_q - 4'h1;
            end
            if (is_ref && all_idle && busy_q == 4'h0) begin
                refresh_row <= (refresh_row == ROW_CNT_MAX)
                    ? '0 : refresh_row + 13'h1;
                busy_q <= RFC_CK;
                if (!cmd_in.clk_gate && !AUTOMOTIVE) begin
                    self_refresh <= 1'b1;
                end
            end else if (is_cfg && all_idle && busy_q == 4'h0) begin
                config_word <= cmd_in.addr[11:0];
                busy_q <= MRD_CK;
            end else if (self_refresh) begin
                if (cmd_in.clk_gate) begin
                    self_refresh <= 1'b0;
                end else if (busy_q == 4'h0) begin
                    refresh_row <= (refresh_row == ROW_CNT_MAX)
                        ? '0 : refresh_row + 13'h1;
                    busy_q <= RFC_CK;
                end
            end
        end
    end
endmodule

/* hdl/sdc_fifo.sv */
`timescale 1ns/10ps
module sdc_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 16
) (
    input wire logic clk, // clock
    input wire logic rst, // async reset
    input wire logic in_valid, // write request
    output logic in_ready, // not full
    input wire logic [WIDTH-1:0] in_data, // write word
    output logic out_valid, // not empty
    input wire logic out_ready, // read accept
    output logic [WIDTH-1:0] out_data // head word
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    logic push;
    logic pop;

    assign in_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
    assign out_valid = wr_q != rd_q;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_q[rd_q[AW-1:0]];

    // storage
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= in_data;
        end
    end

    // pointers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end
endmodule

/* hdl/sdc_mem.sv */
`timescale 1ns/10ps
module sdc_mem
    import sdc_pkg::*;
(
    input wire logic clk, // clock
    input wire logic wr_en, // write strobe
    input wire logic [MASK_BITS-1:0] wr_mask, // byte mask, high skips
    input wire logic [MEM_ABITS-1:0] addr, // word address
    input wire logic [DATA_BITS-1:0] wr_data, // write word
    output logic [DATA_BITS-1:0] rd_data // registered read word
);
    logic [DATA_BITS-1:0] mem_q [MEM_WORDS];

    // per-byte masked write; one process so the array has one driver
    always_ff @(posedge clk) begin
        if (wr_en) begin
            for (int b = 0; b < MASK_BITS; b++) begin
                if (!wr_mask[b]) begin
                    mem_q[addr][b*8 +: 8] <= wr_data[b*8 +: 8];
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        rd_data <= mem_q[addr];
    end
endmodule

/* hdl/sdc_pkg.sv */
package sdc_pkg;
    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int NUM_BANKS = 4;
    localparam int ROW_BITS = 13;
    localparam int ADDR_BITS = 13;
    localparam int COL_BITS = 9;          // 512 columns, 16-bit variant
    localparam int DATA_BITS = 16;
    localparam int MASK_BITS = 2;
    localparam int NUM_ROWS = 8192;
    localparam int AP_LINE = 10;          // auto precharge / all-bank line
    localparam int FIFO_DEPTH = 16;
    localparam int READ_MASK_LAT = 2;     // mask to high-z during reads
    localparam int BURST_LEN = 4;
    localparam int MEM_WORDS = 256;       // modelled words per device
    localparam int MEM_ABITS = 8;
    // ------------------------------------------------------------
    // timing at 20 MHz
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int PRECHARGE_WAIT_NS = 20;
    localparam int REFRESH_CYCLE_NS = 66;
    localparam int CONFIG_LOAD_WAIT_CK = 2;
    localparam int PRECHARGE_WAIT_CK =
        (PRECHARGE_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int REFRESH_CYCLE_CK =
        (REFRESH_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] PRE_CK = 4'(PRECHARGE_WAIT_CK);
    localparam logic [3:0] RFC_CK = 4'(REFRESH_CYCLE_CK);
    localparam logic [3:0] MRD_CK = 4'(CONFIG_LOAD_WAIT_CK);
    localparam logic [2:0] BL_LAST = 3'(BURST_LEN - 1);
    localparam logic [12:0] ROW_CNT_MAX = 13'h1fff;

    // strobe code {ras_n, cas_n, we_n}
    typedef enum logic [2:0] {
        SDC_CMD_CONFIG_LOAD = 3'b000,
        SDC_CMD_REFRESH = 3'b001,
        SDC_CMD_PRECHARGE = 3'b010,
        SDC_CMD_ACTIVE = 3'b011,
        SDC_CMD_WRITE = 3'b100,
        SDC_CMD_READ = 3'b101,
        SDC_CMD_TERMINATE = 3'b110,
        SDC_CMD_NOP = 3'b111
    } sdc_cmd_t;

    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic clk_gate;
        logic bank_select_hi;
        logic bank_select_lo;
        logic [ADDR_BITS-1:0] addr;
        logic [MASK_BITS-1:0] mask;
    } sdc_cmd_bus_t;

    typedef struct packed {
        logic [MASK_BITS-1:0] mask;
        logic [DATA_BITS-1:0] data;
    } sdc_word_t;
endpackage

/* test/sdc_ctrl_model.sv */
`timescale 1ns/10ps
module sdc_ctrl_model
    import sdc_pkg::*;
(
    input wire logic clk, // device clock
    output sdc_cmd_bus_t cmd, // command bus to device
    output logic [DATA_BITS-1:0] dq // write data to device
);
    // ------------------------------------------------------------
    // one command per cycle, waits filled with nops
    // ------------------------------------------------------------
    initial begin
        cmd = {1'b0, SDC_CMD_NOP, 1'b1, 2'b00, 13'h0000, 2'b00};
        dq = 16'h0000;
    end
    // idle data line shows the inverse of its last value
    task automatic beat(input logic [1:0] m, input logic [15:0] d,
                        input logic gate);
        @(posedge clk);
        cmd <= {1'b0, SDC_CMD_NOP, gate, 2'b00, 13'h0000, m};
        dq <= d;
    endtask
    task automatic issue(input sdc_cmd_t c, input logic [1:0] bk,
                         input logic [12:0] a, input logic [1:0] m,
                         input logic [15:0] d, input logic sel_n,
                         input logic gate);
        int w;
        w = c == SDC_CMD_PRECHARGE ? PRECHARGE_WAIT_CK :
            c == SDC_CMD_REFRESH ? REFRESH_CYCLE_CK :
            c == SDC_CMD_CONFIG_LOAD ? CONFIG_LOAD_WAIT_CK : 0;
        @(posedge clk);
        cmd <= {sel_n, c, gate, bk, a, m};
        dq <= d;
        repeat (w) beat(2'b00, ~d, gate);
    endtask
endmodule

/* test/sdc_device_assertions.sv */
`timescale 1ns/10ps
module sdc_device_assertions
    import sdc_pkg::*;
#(
    parameter bit AUTOMOTIVE = 1'b0
) (
    input wire logic clk, // device clock
    input wire logic rst, // async reset
    input wire sdc_cmd_bus_t cmd_in, // command bus
    input wire logic [DATA_BITS-1:0] dq_in, // write data
    input wire logic [DATA_BITS-1:0] dq_out, // read data
    input wire logic [DATA_BITS-1:0] dq_oe, // drive enables
    input wire logic [ROW_BITS-1:0] refresh_row, // refresh row
    input wire logic self_refresh, // self refresh state
    input wire logic [NUM_BANKS-1:0] bank_open, // open banks
    input wire logic [11:0] config_word // config op-code
);
    // ------------------------------------------------------------
    // decoded command helpers
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic [2:0] code;
    logic live, is_act, is_pre, is_cfg, is_ref, sr_go, m0, m1;
    logic [3:0] bsel;
    logic [11:0] cfg_op;
    assign code = {cmd_in.ras_n, cmd_in.cas_n, cmd_in.we_n};
    assign live = !cmd_in.cs_n && cmd_in.clk_gate && !self_refresh;
    assign is_act = live && code == SDC_CMD_ACTIVE;
    assign is_pre = live && code == SDC_CMD_PRECHARGE;
    assign is_cfg = live && code == SDC_CMD_CONFIG_LOAD;
    assign is_ref = live && code == SDC_CMD_REFRESH;
    assign sr_go = !cmd_in.cs_n && !cmd_in.clk_gate && !self_refresh &&
        code == SDC_CMD_REFRESH;
    assign bsel = 4'b0001 << {cmd_in.bank_select_hi, cmd_in.bank_select_lo};
    assign cfg_op = cmd_in.addr[11:0];
    assign m0 = cmd_in.mask[0];
    assign m1 = cmd_in.mask[1];
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    mask_lo_a: assert property (dq_oe[7:0] != 8'h00 |->
        $past(m0, 2) == 1'b0) else $error("low lane driven while masked");
    mask_hi_a: assert property (dq_oe[15:8] != 8'h00 |->
        $past(m1, 2) == 1'b0) else $error("high lane driven while masked");
    deselect_hold_a: assert property (cmd_in.cs_n |=>
        (bank_open & ~$past(bank_open)) == 4'b0000 && $stable(config_word))
        else $error("deselected device took a command");
    nop_hold_a: assert property (!cmd_in.cs_n && code == SDC_CMD_NOP |=>
        (bank_open & ~$past(bank_open)) == 4'b0000 && $stable(config_word))
        else $error("nop started an operation");
    open_cause_a: assert property ((bank_open & ~$past(bank_open)) != 0
        |-> $past(is_act) && (bank_open & ~$past(bank_open)) == $past(bsel))
        else $error("bank opened without matching active");
    pre_all_a: assert property (is_pre && cmd_in.addr[AP_LINE] |=>
        bank_open == 4'b0000) else $error("precharge all left a bank open");
    pre_one_a: assert property (is_pre && !cmd_in.addr[AP_LINE] |=>
        (bank_open & $past(bsel)) == 4'b0000)
        else $error("precharged bank still open");
    cfg_load_a: assert property ($changed(config_word) |->
        $past(is_cfg) && config_word == $past(cfg_op))
        else $error("config word changed without load");
    refresh_step_a: assert property ($changed(refresh_row) &&
        !self_refresh && !$past(self_refresh) |->
        ($past(is_ref) || $past(is_ref, 2)) &&
        refresh_row == $past(refresh_row) + 13'h0001)
        else $error("refresh row stepped wrongly");
    sr_entry_a: assert property ($rose(self_refresh) |-> $past(sr_go))
        else $error("self refresh entered without command");
    sr_hold_a: assert property (self_refresh && !cmd_in.clk_gate |=>
        self_refresh && bank_open == 4'b0000)
        else $error("self refresh left with clock gate low");
    no_sr_auto_a: assert property (!(AUTOMOTIVE && self_refresh))
        else $error("self refresh on automotive variant");
    cover property (dq_oe != 16'h0000);
    cover property ($rose(self_refresh));
    cover property (is_pre && cmd_in.addr[AP_LINE]);
endmodule

/* test/test_sdram_command_interface.sv */
`timescale 1ns/10ps
module test_sdram_command_interface import sdc_pkg::*;;
    logic clk, rst;
    sdc_cmd_bus_t cmd;
    logic [15:0] dq_in, dq_out, dq_oe, dq_prev;
    logic [12:0] refresh_row;
    logic self_refresh;
    logic [3:0] bank_open;
    logic [11:0] config_word, cfg;
    logic [5:0] col;
    logic [31:0] e;
    logic [31:0] exp_q[$];
    logic [15:0] mem_m [MEM_WORDS];
    int errors, compares, seed;
    sdc_ctrl_model m (.clk(clk), .cmd(cmd), .dq(dq_in));
    sdc_device #(.AUTOMOTIVE(1'b0)) uut (.clk(clk), .rst(rst), .cmd_in(cmd),
        .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
        .refresh_row(refresh_row), .self_refresh(self_refresh),
        .bank_open(bank_open), .config_word(config_word));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want) begin
            errors++;
            $display("BAD %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic complete_run();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic nop();
        m.beat(2'b00, ~dq_in, 1'b1);
    endtask
    task automatic cmdx(input sdc_cmd_t c, input logic [1:0] bk,
                        input logic [12:0] a, input logic gate);
        m.issue(c, bk, a, 2'b00, 16'h0000, 1'b0, gate);
    endtask
    task automatic wr(input logic [1:0] bk, input logic full);
        logic [15:0] d;
        logic [1:0] mk;
        logic [7:0] ix;
        for (int i = 0; i < BURST_LEN; i++) begin
            d = 16'($random(seed));
            mk = full ? 2'b00 : 2'($random(seed));
            ix = {bk, col + 6'(i)};
            if (!mk[0]) mem_m[ix][7:0] = d[7:0];
            if (!mk[1]) mem_m[ix][15:8] = d[15:8];
            if (i == 0) m.issue(SDC_CMD_WRITE, bk, {7'h00, col}, mk, d,
                1'b0, 1'b1);
            else m.beat(mk, d, 1'b1);
        end
    endtask
    task automatic rd(input logic [1:0] bk, input logic ap, input int n);
        logic [1:0] mk;
        for (int i = 0; i < BURST_LEN; i++) begin
            mk = 2'($unsigned($random(seed)) % 3);
            if (i < n) exp_q.push_back({{8{~mk[1]}}, {8{~mk[0]}},
                mem_m[{bk, col + 6'(i)}]});
            if (i == 0) m.issue(SDC_CMD_READ, bk, {2'b00, ap, 4'h0, col},
                mk, 16'h0000, 1'b0, 1'b1);
            else if (i == n) m.issue(SDC_CMD_TERMINATE, 2'b00, 13'h0000,
                mk, 16'h0000, 1'b0, 1'b1);
            else m.beat(mk, ~dq_in, 1'b1);
        end
        repeat (4) nop();
    endtask
    // ------------------------------------------------------------
    // read monitor against noted results
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (!rst && dq_oe !== 16'h0000) begin
            e = exp_q.size() > 0 ? exp_q.pop_front() : 32'h0000_0000;
            check(dq_oe, e[31:16]);
            check(dq_prev & dq_oe, e[15:0] & dq_oe);
        end
        dq_prev <= dq_out;
    end
    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        complete_run();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 34057;
        errors = 0;
        compares = 0;
        rst = 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        nop();
        @(negedge clk);
        check({bank_open, self_refresh, config_word, refresh_row}, 0);
        repeat (2000) nop();
        repeat (2) cmdx(SDC_CMD_REFRESH, 2'b11, 13'($random(seed)), 1'b1);
        cfg = 12'($random(seed));
        cmdx(SDC_CMD_CONFIG_LOAD, 2'b00, {1'b0, cfg}, 1'b1);
        @(negedge clk);
        check(config_word, cfg);
        check(refresh_row, 2);
        m.issue(SDC_CMD_ACTIVE, 2'b00, 13'h0005, 2'b00, 16'h0000, 1'b1,
            1'b1);
        nop();
        @(negedge clk);
        check(bank_open, 0);
        for (int b = 0; b < NUM_BANKS; b++) begin
            cmdx(SDC_CMD_ACTIVE, 2'(b), 13'($random(seed)), 1'b1);
            nop();
            @(negedge clk);
            check(bank_open, (1 << (b + 1)) - 1);
            col = 6'($random(seed)) & 6'h3c;
            wr(2'(b), 1'b1);
            wr(2'(b), 1'b0);
            repeat (24) nop();
            rd(2'(b), 1'b0, 4);
            rd(2'(b), 1'b0, 2);
        end
        rd(2'd3, 1'b1, 4);
        @(negedge clk);
        check(bank_open, 4'b0111);
        cmdx(SDC_CMD_PRECHARGE, 2'b00, 13'h0000, 1'b1);
        @(negedge clk);
        check(bank_open, 4'b0110);
        cmdx(SDC_CMD_PRECHARGE, 2'b01, 13'h0400, 1'b1);
        @(negedge clk);
        check(bank_open, 0);
        cmdx(SDC_CMD_REFRESH, 2'b00, 13'h0000, 1'b0);
        cmdx(SDC_CMD_ACTIVE, 2'b00, 13'h0001, 1'b0);
        repeat (8) m.beat(2'b00, ~dq_in, 1'b0);
        @(negedge clk);
        check({self_refresh, bank_open}, 5'b10000);
        repeat (3) nop();
        @(negedge clk);
        check(self_refresh, 0);
        cmdx(SDC_CMD_REFRESH, 2'b00, 13'h0000, 1'b1);
        check(exp_q.size(), 0);
        complete_run();
    end
endmodule
bind sdc_device sdc_device_assertions #(.AUTOMOTIVE(AUTOMOTIVE)) chk (
    .clk(clk), .rst(rst), .cmd_in(cmd_in), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe(dq_oe), .refresh_row(refresh_row), .self_refresh(self_refresh),
    .bank_open(bank_open), .config_word(config_word));
